/* logic/dsu_uart.sv */
`timescale 1ns/1ps
// Overview of operation
// - status bit 3 set when new byte lands on unread data, else cleared
// - status bit 2 high while receive holding has unread byte
// - status bit 1 high while transmit holding is occupied
// - status bit 0 high while transmit shifter is sending
// - low-byte port read gives byte on 7:0, zeros on 15:8
// - reading received byte clears holding-full indication
// - receive interrupt pulses when byte moves into receive holding
// - low-byte port write sends only bits 7:0
// - write while idle loads shifter, pulses transmit interrupt, starts sending
// - write while busy, except in the stop bit's last cycle with holding empty, sets holding-full, byte waits for previous character
// - high-byte port acts like low-byte port on bits 15:8
// - divider register: prescale in 15-8, bit divider in 7-0
// - divider register resets to zero
// - bit rate is clock over (prescale plus 1) times bit divider
// - receiver samples on prescaler output ticks
// - falling edge on receive line starts a start bit
// - eight data bits sampled mid-bit, shifted in lsb first
// - good stop bit: store byte, interrupt, copy bit2 to bit3 unless a read comes in that cycle, set bit2
// - transmit holding empties when its byte enters the shifter
// - frame: low start, eight data lsb first, high stop, idle high
module dsu_uart (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic [1:0]  i_addr,
  input  wire logic [15:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [15:0] o_rdata,
  input  wire logic        i_rxd,
  output logic             o_txd,
  output logic             o_tx_interrupt,
  output logic             o_rx_interrupt
);

  ////////////////////////////////////////////////////////////////////////
  // registers and shared state

  dsu_pkg::dsu_div_t   div_r;
  dsu_pkg::dsu_flags_t flags;
  logic [7:0]  pre_cnt_r;
  logic        pre_tick;
  logic [7:0]  tx_hold_r;
  logic        tx_full_r;
  logic [9:0]  tx_shift_r;
  logic [3:0]  tx_bits_r;
  logic [7:0]  tx_bcnt_r;
  logic        tx_active_r;
  logic        rx_meta_r;
  logic        rx_sync_r;
  logic        rx_prev_r;
  logic [7:0]  rx_hold_r;
  logic        rx_full_r;
  logic        rx_orun_r;
  logic [7:0]  rx_shift_r;
  logic [3:0]  rx_bits_r;
  logic [7:0]  rx_bcnt_r;
  logic        rx_done;
  logic        rx_good;
  logic        data_wr;
  logic        data_rd;
  logic        tx_load;
  logic        tx_end;

  typedef enum logic [1:0] {DSU_RX_IDLE, DSU_RX_START, DSU_RX_DATA, DSU_RX_STOP} dsu_rx_state_t;
  dsu_rx_state_t rx_state_r;

  // data port select: low port takes bits 7:0, high port bits 15:8
  function automatic logic [7:0] pick_byte(input logic [1:0] a, input logic [15:0] d);
    pick_byte = (a == dsu_pkg::REG_HIGH) ? d[15:8] : d[7:0];
  endfunction

  // clocks in one whole frame at the programmed divider, for the length check
  function automatic logic [19:0] frame_clks(input dsu_pkg::dsu_div_t d);
    frame_clks = 20'(dsu_pkg::FRAME_BITS) * (20'(d.prescale_divider) + 20'h0_0001) * 20'(d.bit_divider);
  endfunction

  assign data_wr = i_wr && (i_addr == dsu_pkg::REG_LOW || i_addr == dsu_pkg::REG_HIGH);
  assign data_rd = i_rd && (i_addr == dsu_pkg::REG_LOW || i_addr == dsu_pkg::REG_HIGH);

  ////////////////////////////////////////////////////////////////////////
  // divider register, reset to zero, fields as documented

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      div_r <= dsu_pkg::DIV_RESET;
    end else if (i_wr && i_addr == dsu_pkg::REG_DIV) begin
      div_r <= i_wdata;
    end
  end

  // prescaler: one tick every (prescale+1) clocks, feeds both bit timers
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pre_cnt_r <= 8'h00;
    end else if (pre_cnt_r >= div_r.prescale_divider) begin
      pre_cnt_r <= 8'h00;
    end else begin
      pre_cnt_r <= pre_cnt_r + 8'h01;
    end
  end
  assign pre_tick = (pre_cnt_r >= div_r.prescale_divider);

  ////////////////////////////////////////////////////////////////////////
  // transmitter

  // start when shifter idle and either a direct write or a held byte waits;
  // a write in the stop bit's last cycle goes straight in unless a held byte waits; then the held byte goes in and the write is held
  assign tx_end  = tx_active_r && pre_tick && (tx_bcnt_r <= 8'h01) && (tx_bits_r == 4'h1);
  assign tx_load = (data_wr && (!tx_active_r || (tx_end && !tx_full_r))) || (tx_end && tx_full_r);

  // holding register: only used when the shifter is busy
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      tx_full_r <= 1'b0;
      tx_hold_r <= 8'h00;
    end else if (data_wr && tx_active_r && !tx_end) begin
      tx_full_r <= 1'b1;
      tx_hold_r <= pick_byte(i_addr, i_wdata);
    end else if (data_wr && tx_end && tx_full_r) begin
      tx_hold_r <= pick_byte(i_addr, i_wdata); // software broke the full rule; keep newest
    end else if (tx_end && tx_full_r) begin
      tx_full_r <= 1'b0;
    end else if (data_wr && tx_end) begin
      tx_full_r <= 1'b0;
    end
  end

  // shifter: stop,data,start; one bit per bit_divider prescaler ticks
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      tx_shift_r  <= 10'h3ff;
      tx_bits_r   <= 4'h0;
      tx_bcnt_r   <= 8'h00;
      tx_active_r <= 1'b0;
    end else if (tx_load) begin
      tx_shift_r  <= {1'b1, (tx_full_r ? tx_hold_r : pick_byte(i_addr, i_wdata)), 1'b0};
      tx_bits_r   <= 4'(dsu_pkg::FRAME_BITS);
      tx_bcnt_r   <= div_r.bit_divider;
      tx_active_r <= 1'b1;
    end else if (tx_end) begin
      tx_active_r <= 1'b0;
      tx_shift_r  <= 10'h3ff;
    end else if (tx_active_r && pre_tick) begin
      if (tx_bcnt_r <= 8'h01) begin
        tx_bcnt_r  <= div_r.bit_divider;
        tx_bits_r  <= tx_bits_r - 4'h1;
        tx_shift_r <= {1'b1, tx_shift_r[9:1]}; // lsb first
      end else begin
        tx_bcnt_r <= tx_bcnt_r - 8'h01;
      end
    end
  end

  assign o_txd = tx_shift_r[0]; // idles high from reset

  // interrupt pulse whenever a byte starts shifting
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_tx_interrupt <= 1'b0;
    end else begin
      o_tx_interrupt <= tx_load;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // receiver: pin is asynchronous, so two flops before any logic
  // all three reset to the idle level, so leaving reset fakes no start edge

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rx_meta_r <= 1'b1;
      rx_sync_r <= 1'b1;
      rx_prev_r <= 1'b1;
    end else begin
      rx_meta_r <= i_rxd;
      rx_sync_r <= rx_meta_r;
      rx_prev_r <= rx_sync_r;
    end
  end

  // bit timer counts prescaler ticks; start waits half a bit to hit mid-bit
  assign rx_done = (rx_state_r == DSU_RX_STOP) && pre_tick && (rx_bcnt_r <= 8'h01);
  assign rx_good = rx_done && rx_sync_r;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rx_state_r <= DSU_RX_IDLE;
      rx_bcnt_r  <= 8'h00;
      rx_bits_r  <= 4'h0;
      rx_shift_r <= 8'h00;
    end else begin
      case (rx_state_r)
        DSU_RX_IDLE: begin
          if (rx_prev_r && !rx_sync_r) begin
            rx_state_r <= DSU_RX_START;
            rx_bcnt_r  <= {1'b0, div_r.bit_divider[7:1]};
          end
        end
        DSU_RX_START: begin
          if (pre_tick) begin
            if (rx_bcnt_r <= 8'h01) begin
              // a glitch that is gone by mid-start is not a start bit
              rx_state_r <= rx_sync_r ? DSU_RX_IDLE : DSU_RX_DATA;
              rx_bcnt_r  <= div_r.bit_divider;
              rx_bits_r  <= 4'(dsu_pkg::DATA_BITS);
            end else begin
              rx_bcnt_r <= rx_bcnt_r - 8'h01;
            end
          end
        end
        DSU_RX_DATA: begin
          if (pre_tick) begin
            if (rx_bcnt_r <= 8'h01) begin
              rx_shift_r <= {rx_sync_r, rx_shift_r[7:1]};
              rx_bcnt_r  <= div_r.bit_divider;
              rx_bits_r  <= rx_bits_r - 4'h1;
              if (rx_bits_r == 4'h1) begin
                rx_state_r <= DSU_RX_STOP;
              end
            end else begin
              rx_bcnt_r <= rx_bcnt_r - 8'h01;
            end
          end
        end
        DSU_RX_STOP: begin
          if (pre_tick) begin
            if (rx_bcnt_r <= 8'h01) begin
              rx_state_r <= DSU_RX_IDLE; // low stop drops the byte
            end else begin
              rx_bcnt_r <= rx_bcnt_r - 8'h01;
            end
          end
        end
        default: begin
          rx_state_r <= DSU_RX_IDLE;
        end
      endcase
    end
  end

  // holding register and its flags; a new byte wins over a same-cycle read
  // a read in the store cycle took the old byte, so that is no overrun
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rx_hold_r <= 8'h00;
      rx_full_r <= 1'b0;
      rx_orun_r <= 1'b0;
    end else if (rx_good) begin
      rx_hold_r <= rx_shift_r;
      rx_orun_r <= rx_full_r && !data_rd;
      rx_full_r <= 1'b1;
    end else if (data_rd) begin
      rx_full_r <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rx_interrupt <= 1'b0;
    end else begin
      o_rx_interrupt <= rx_good;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read port: data valid in the cycle after the strobe
  // zero outside the answer cycle, so a stale word never looks valid

  always_comb begin
    flags.rx_overrun_flag   = rx_orun_r;
    flags.rx_holding_full   = rx_full_r;
    flags.tx_holding_full   = tx_full_r;
    flags.tx_shifter_active = tx_active_r;
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= 16'h0000;
    end else if (!i_rd) begin
      o_rdata <= 16'h0000;
    end else if (i_addr == dsu_pkg::REG_FLAGS) begin
      o_rdata <= {12'h000, flags};
    end else if (i_addr == dsu_pkg::REG_LOW) begin
      o_rdata <= {8'h00, rx_hold_r};
    end else if (i_addr == dsu_pkg::REG_HIGH) begin
      o_rdata <= {rx_hold_r, 8'h00};
    end else begin
      o_rdata <= div_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks

  // receiver checks
  a_rx_irq_full: assert property (@(posedge i_clk) disable iff (i_rst)
    rx_good |=> (o_rx_interrupt && rx_full_r))
    else $error("rx byte did not raise full and irq");
  a_rx_overrun_copy: assert property (@(posedge i_clk) disable iff (i_rst)
    (rx_good && !data_rd) |=> (rx_orun_r == $past(rx_full_r)))
    else $error("overrun not copy of full");
  a_rx_read_clear: assert property (@(posedge i_clk) disable iff (i_rst)
    (data_rd && !rx_good) |=> !rx_full_r)
    else $error("read did not clear full");
  a_rx_bad_stop: assert property (@(posedge i_clk) disable iff (i_rst)
    (rx_done && !rx_sync_r && !data_rd) |=> ($stable(rx_full_r) && $stable(rx_orun_r) && $stable(rx_hold_r)))
    else $error("bad stop changed flags");
  a_rx_full_keep: assert property (@(posedge i_clk) disable iff (i_rst)
    (rx_full_r && !data_rd) |=> rx_full_r)
    else $error("unread byte lost its full flag");
  a_rx_orun_keep: assert property (@(posedge i_clk) disable iff (i_rst)
    !rx_good |=> $stable(rx_orun_r))
    else $error("overrun changed without a stored byte");

  // transmitter checks
  a_tx_idle_start: assert property (@(posedge i_clk) disable iff (i_rst)
    (data_wr && !tx_active_r) |=> (tx_active_r && !tx_full_r && o_tx_interrupt && !o_txd))
    else $error("idle write did not start");
  a_tx_busy_hold: assert property (@(posedge i_clk) disable iff (i_rst)
    (data_wr && tx_active_r && !tx_end) |=> tx_full_r)
    else $error("busy write not held");
  a_tx_end_write: assert property (@(posedge i_clk) disable iff (i_rst)
    (data_wr && tx_end && !tx_full_r) |=> (tx_active_r && !tx_full_r && o_tx_interrupt && !o_txd))
    else $error("write at frame end was lost");
  a_tx_hold_moves: assert property (@(posedge i_clk) disable iff (i_rst)
    (tx_end && tx_full_r && !data_wr) |=> (!tx_full_r && tx_active_r && o_tx_interrupt))
    else $error("held byte did not start");
  a_tx_full_keep: assert property (@(posedge i_clk) disable iff (i_rst)
    (tx_full_r && !tx_end) |=> tx_full_r)
    else $error("held byte flag dropped early");
  a_tx_active_keep: assert property (@(posedge i_clk) disable iff (i_rst)
    (tx_active_r && !tx_end) |=> tx_active_r)
    else $error("shifter stopped inside a frame");
  a_tx_idle_line: assert property (@(posedge i_clk) disable iff (i_rst)
    !tx_active_r |-> o_txd)
    else $error("line not high when idle");
  a_tx_stop_high: assert property (@(posedge i_clk) disable iff (i_rst)
    tx_end |-> o_txd)
    else $error("stop bit not high");

  // helper for the frame-length check: clocks since the frame was loaded
  logic [19:0] tx_clks_r;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      tx_clks_r <= 20'h0_0000;
    end else if (tx_load) begin
      tx_clks_r <= 20'h0_0001;
    end else if (tx_active_r) begin
      tx_clks_r <= tx_clks_r + 20'h0_0001;
    end
  end

  // the first tick after a load may come up to prescale_divider clocks early, so a frame may run that much short
  a_tx_frame_len: assert property (@(posedge i_clk) disable iff (i_rst)
    tx_end |-> ((tx_clks_r <= frame_clks(div_r)) && (tx_clks_r + 20'(div_r.prescale_divider) >= frame_clks(div_r))))
    else $error("frame length off the divider product");

  // register port checks
  a_div_read: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_rd && i_addr == dsu_pkg::REG_DIV) |=> (o_rdata == $past(div_r)))
    else $error("divider readback wrong");
  a_div_write: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_wr && i_addr == dsu_pkg::REG_DIV) |=> (div_r == $past(i_wdata)))
    else $error("divider write not taken");
  a_low_read: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_rd && i_addr == dsu_pkg::REG_LOW) |=> (o_rdata == {8'h00, $past(rx_hold_r)}))
    else $error("low port read wrong");
  a_high_read: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_rd && i_addr == dsu_pkg::REG_HIGH) |=> (o_rdata == {$past(rx_hold_r), 8'h00}))
    else $error("high port read wrong");
  a_flags_read: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_rd && i_addr == dsu_pkg::REG_FLAGS) |=> (o_rdata == {12'h000, $past(flags)}))
    else $error("status read wrong");

endmodule

/* pkg/dsu_pkg.sv */
package dsu_pkg;

  // register indices on the plain register port
  localparam logic [1:0] REG_FLAGS = 2'h0;
  localparam logic [1:0] REG_LOW   = 2'h1;
  localparam logic [1:0] REG_HIGH  = 2'h2;
  localparam logic [1:0] REG_DIV   = 2'h3;

  // line_state_flags bit positions
  localparam int FLAG_TX_ACTIVE  = 0;
  localparam int FLAG_TX_FULL    = 1;
  localparam int FLAG_RX_FULL    = 2;
  localparam int FLAG_RX_OVERRUN = 3;

  // divider fields and reset value
  localparam int            DIV_PRE_LSB = 8;
  localparam int            DIV_BIT_LSB = 0;
  localparam logic [15:0]   DIV_RESET   = 16'h0000;

  // character framing
  localparam int            DATA_BITS   = 8;
  localparam int            FRAME_BITS  = 10;

  typedef struct packed {
    logic       rx_overrun_flag;
    logic       rx_holding_full;
    logic       tx_holding_full;
    logic       tx_shifter_active;
  } dsu_flags_t;

  typedef struct packed {
    logic [7:0] prescale_divider;
    logic [7:0] bit_divider;
  } dsu_div_t;

endpackage

/* verif/dsu_term.sv */
`timescale 1ns/1ps
// serial terminal on the far end of the line
module dsu_term #(
  parameter int BIT_CLKS = 12
) (
  input  wire logic       i_clk,
  input  wire logic       i_txd,
  output logic            o_rxd,
  output logic [7:0]      o_byte,
  output logic            o_ferr,
  output int              o_count
);
  logic [7:0] sh;

  // line idles high before anything is sent
  initial begin
    o_rxd = 1'b1;
    o_byte = 8'h00;
    o_ferr = 1'b0;
    o_count = 0;
  end

  ////////////////////////////////////////////////////////////
  // one character; a low stop only when a scenario wants a fault
  task automatic send(input logic [7:0] b, input logic stop);
    logic [9:0] fr;
    fr = {stop, b, 1'b0}; // start low, lsb first
    @(posedge i_clk);
    for (int i = 0; i < 10; i++) begin
      o_rxd <= fr[i];
      repeat (BIT_CLKS) @(posedge i_clk);
    end
    o_rxd <= 1'b1; // idle high between characters
  endtask

  ////////////////////////////////////////////////////////////
  // mid-bit sampling, so a wrong bit rate garbles the byte
  initial begin
    forever begin
      @(negedge i_txd);
      repeat (BIT_CLKS / 2) @(posedge i_clk);
      if (i_txd !== 1'b0) o_ferr <= 1'b1; // start bit low
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_CLKS) @(posedge i_clk);
        sh[i] = i_txd; // lsb first
      end
      repeat (BIT_CLKS) @(posedge i_clk);
      if (i_txd !== 1'b1) o_ferr <= 1'b1; // stop bit high
      o_byte <= sh;
      o_count <= o_count + 1;
    end
  end
endmodule

/* verif/dsu_uart_tb.sv */
`timescale 1ns/1ps
module dsu_uart_tb;
  // prescale 1 and bit divider 6 give 12 clocks a bit
  localparam int BIT_CLKS = 12;
  logic        i_clk;
  logic        i_rst;
  logic [1:0]  i_addr;
  logic [15:0] i_wdata;
  logic        i_wr;
  logic        i_rd;
  logic [15:0] o_rdata;
  logic        i_rxd;
  logic        o_txd;
  logic        o_tx_interrupt;
  logic        o_rx_interrupt;
  logic [7:0]  t_byte;
  logic        t_ferr;
  int          t_count;
  int          err_total;
  int          check_count;
  int          txi_n;
  int          rxi_n;

  dsu_uart uut (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_rxd(i_rxd), .o_txd(o_txd),
    .o_tx_interrupt(o_tx_interrupt), .o_rx_interrupt(o_rx_interrupt));
  dsu_term #(.BIT_CLKS(BIT_CLKS)) term (.i_clk(i_clk), .i_txd(o_txd), .o_rxd(i_rxd),
    .o_byte(t_byte), .o_ferr(t_ferr), .o_count(t_count));

  // 40 MHz clock
  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end

  // a pulse that stays high is counted more than once
  always @(posedge i_clk) begin
    if (o_tx_interrupt === 1'b1) txi_n <= txi_n + 1;
    if (o_rx_interrupt === 1'b1) rxi_n <= rxi_n + 1;
  end

  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rdc(input logic [1:0] a, input logic [15:0] exp, input logic [15:0] m = 16'hFFFF);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    chk(o_rdata & m, exp);
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // bounded wait on received-by-terminal or rx interrupt counts
  task automatic wait_for(input logic rx, input int want);
    int n;
    n = 0;
    while ((rx ? rxi_n : t_count) < want && n < 3000) begin
      @(posedge i_clk);
      n++;
    end
    if (n >= 3000) begin
      err_total++;
      $display("unexpected at %0t: wait ran out", $time);
      finish_test();
    end
  endtask

  ////////////////////////////////////////////////////////////
  initial begin
    i_rst = 1'b1;
    i_addr = 2'h0;
    i_wdata = 16'h0000;
    i_wr = 1'b0;
    i_rd = 1'b0;
    err_total = 0;
    check_count = 0;
    txi_n = 0;
    rxi_n = 0;
    repeat (20) @(posedge i_clk);
    i_rst <= 1'b0;
    rdc(dsu_pkg::REG_DIV, dsu_pkg::DIV_RESET);
    wr(dsu_pkg::REG_FLAGS, 16'hFFFF);
    rdc(dsu_pkg::REG_FLAGS, 16'h0000);
    wr(dsu_pkg::REG_DIV, 16'h0106); // bit divider kept in 6..255
    rdc(dsu_pkg::REG_DIV, 16'h0106);
    $display("test registers done");
    // second byte goes in while the first is shifting
    wr(dsu_pkg::REG_LOW, 16'hAB5A);
    wr(dsu_pkg::REG_HIGH, 16'hC300); // holding was empty
    rdc(dsu_pkg::REG_FLAGS, 16'h0003);
    chk(16'(txi_n), 16'h0001);
    wait_for(1'b0, 1);
    chk({8'h00, t_byte}, 16'h005A);
    wait_for(1'b0, 2);
    chk({8'h00, t_byte}, 16'h00C3);
    chk(16'(txi_n), 16'h0002);
    repeat (BIT_CLKS) @(posedge i_clk);
    rdc(dsu_pkg::REG_FLAGS, 16'h0000);
    // prescale 0 makes a frame exactly 120 clocks, so the next write hits the stop bit's last cycle
    wr(dsu_pkg::REG_DIV, 16'h000C); // still 12 clocks a bit
    wr(dsu_pkg::REG_LOW, 16'h0042);
    repeat (118) @(posedge i_clk);
    wr(dsu_pkg::REG_LOW, 16'hFFE7); // lands as the previous frame ends
    rdc(dsu_pkg::REG_FLAGS, 16'h0001); // nothing held, shifter busy
    chk(16'(txi_n), 16'h0004);
    chk({8'h00, t_byte}, 16'h0042);
    wait_for(1'b0, 4);
    chk({8'h00, t_byte}, 16'h00E7);
    repeat (BIT_CLKS) @(posedge i_clk);
    wr(dsu_pkg::REG_DIV, 16'h0106); // back to prescaled ticks
    $display("test transmit done");
    term.send(8'h96, 1'b1);
    wait_for(1'b1, 1);
    rdc(dsu_pkg::REG_FLAGS, 16'h0004);
    term.send(8'h3C, 1'b1);
    rdc(dsu_pkg::REG_FLAGS, 16'h000C);
    rdc(dsu_pkg::REG_LOW, 16'h003C);
    rdc(dsu_pkg::REG_FLAGS, 16'h0000, 16'h0004);
    term.send(8'hE1, 1'b1);
    rdc(dsu_pkg::REG_FLAGS, 16'h0004);
    rdc(dsu_pkg::REG_HIGH, 16'hE100);
    term.send(8'h77, 1'b0);
    repeat (BIT_CLKS) @(posedge i_clk);
    rdc(dsu_pkg::REG_FLAGS, 16'h0000);
    chk(16'(rxi_n), 16'h0003);
    term.send(8'h21, 1'b1);
    rdc(dsu_pkg::REG_LOW, 16'h0021);
    chk({15'h0000, t_ferr}, 16'h0000);
    $display("test receive done");
    finish_test();
  end
endmodule
